// ===== bench/adsc_chk.sv
// port assertions for the converter control
`timescale 1ns/1ps
module adsc_chk (
   // clock, reset and register port
   input wire logic       ref_clk_in,
   input wire logic       rst_b_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   // sequencer outputs
   input wire logic       sampling_out,
   input wire logic       converting_out,
   input wire logic [6:0] positive_input_sel_out,
   input wire logic [6:0] negative_input_sel_out,
   input wire logic       result_ready_out,
   input wire logic       window_hit_flag_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   // sequencer is in a sample or convert phase
   wire busy = sampling_out || converting_out;
   property p_rdata_idle; !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read cycle");
   property p_unmapped; reg_rd_in && reg_addr_in >= 8'h28
      |=> reg_rdata_out == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_samp_min; $fell(sampling_out) && !$past(reg_wr_in)
      |-> $past(sampling_out, 4); endproperty
   a_samp_min: assert property (p_samp_min)
      else $error("sample phase too short");
   property p_conv_min; $fell(converting_out) && !$past(reg_wr_in)
      |-> $past(converting_out, 8); endproperty
   a_conv_min: assert property (p_conv_min)
      else $error("convert phase too short");
   property p_sel_hold; busy && $past(busy)
      |-> $stable({positive_input_sel_out, negative_input_sel_out});
   endproperty
   a_sel_hold: assert property (p_sel_hold)
      else $error("input select changed mid conversion");
   property p_stop; reg_wr_in && reg_addr_in == 8'h0a && reg_wdata_in[1]
      |-> ##[1:3] !busy; endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not end measurement");
   property p_ready_src; $rose(result_ready_out) |-> $past(converting_out);
   endproperty
   a_ready_src: assert property (p_ready_src)
      else $error("result ready without conversion end");
   property p_win_src; $rose(window_hit_flag_out) |-> $past(converting_out);
   endproperty
   a_win_src: assert property (p_win_src)
      else $error("window flag without conversion end");
   c_ready: cover property ($rose(result_ready_out));
   c_win: cover property ($rose(window_hit_flag_out));
   c_stop: cover property (reg_wr_in && reg_addr_in == 8'h0a);
endmodule
bind adsc_top adsc_chk u_chk (.*);

// ===== bench/adsc_core_model.sv
// behavioural analog core that answers each conversion with a level
`timescale 1ns/1ps
module adsc_core_model (
   // clock and phase from the control
   input  wire logic        ref_clk_in,
   input  wire logic        converting_in,
   input  wire logic [11:0] level_in,
   // raw sample back to the control
   output logic      [11:0] sample_data_out
);
   // outside a conversion the bus is not held: show the inverse level
   always_ff @(posedge ref_clk_in) begin
      sample_data_out <= converting_in ? level_in : ~level_in;
   end
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the converter control
`timescale 1ns/1ps
module tb_top;
   // design ports and bench state
   logic        ref_clk_in, rst_b_in, reg_wr_in, reg_rd_in;
   logic        deep_wake_in, ref_change_in, adc_clk_out;
   logic        sampling_out, converting_out;
   logic        result_ready_out, window_hit_flag_out;
   logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic [11:0] sample_data_in, level;
   logic [6:0]  positive_input_sel_out, negative_input_sel_out;
   logic [15:0] result_out, s_run, c_run, samp_len, conv_len;
   logic [15:0] h_run, h_len, g_run, g_len;
   int          mismatches, cmp_count, cycles, waited, i, j;
   typedef struct packed {logic [7:0] a; logic [7:0] m;} adsc_row_t;
   adsc_row_t   rows [9] = '{'{8'h01, 8'h07}, '{8'h02, 8'h0f},
      '{8'h03, 8'hef}, '{8'h04, 8'h07}, '{8'h05, 8'hff}, '{8'h08, 8'h7f},
      '{8'h09, 8'h7f}, '{8'h0a, 8'h00}, '{8'h30, 8'h00}};
   logic [11:0] lv [5] = '{12'h03ff, 12'h0400, 12'h0450, 12'h0500, 12'h0501};
   int          dc [4] = '{1, 3, 9, 13};
   int          dv [4] = '{4, 12, 48, 256};
   adsc_top dut (.*);
   adsc_core_model core (.ref_clk_in(ref_clk_in), .converting_in(converting_out),
      .level_in(level), .sample_data_out(sample_data_in));
   // 40 MHz clock
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   // phase length monitors and run ceiling
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      s_run <= sampling_out ? s_run + 16'h0001 : 16'h0000;
      h_run <= sampling_out ? h_run + 16'(adc_clk_out) : 16'h0000;
      g_run <= (sampling_out || converting_out) ? 16'h0000 : g_run + 16'h0001;
      if (!sampling_out && s_run != 0) h_len <= h_run;
      if (sampling_out && g_run != 0) g_len <= g_run;
      c_run <= converting_out ? c_run + 16'h0001 : 16'h0000;
      if (!sampling_out && s_run != 0) samp_len <= s_run;
      if (!converting_out && c_run != 0) conv_len <= c_run;
      if (cycles == 30000) begin
         mismatches++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1 chk(16'(reg_rdata_out), 16'(e));
      @(posedge ref_clk_in);
   endtask
   // clear both flags, then command a start
   task automatic start(input logic [11:0] l);
      level <= l;
      wr_reg(8'h21, 8'h03);
      wr_reg(8'h0a, 8'h01);
   endtask
   task automatic wait_ready;
      waited = 0;
      while (result_ready_out !== 1'b1 && waited < 6000) begin
         @(posedge ref_clk_in);
         #1 waited++;
      end
      chk(16'(result_ready_out), 16'h0001);
      @(posedge ref_clk_in);
      #1;
   endtask
   function automatic logic exp_win(input int m, input logic [15:0] r);
      case (m)
         1: return r < 16'h0400;
         2: return r > 16'h0500;
         3: return r >= 16'h0400 && r <= 16'h0500;
         4: return r < 16'h0400 || r > 16'h0500;
         default: return 1'b0;
      endcase
   endfunction
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // stimulus
   initial begin
      {reg_wr_in, reg_rd_in, deep_wake_in, ref_change_in} = 4'h0;
      {reg_addr_in, reg_wdata_in, level} = 28'h000_0000;
      {s_run, c_run, samp_len, conv_len} = 64'h0;
      {h_run, h_len, g_run, g_len} = 64'h0;
      mismatches = 0;
      cmp_count = 0;
      cycles = 0;
      rst_b_in = 1'b0;
      repeat (10) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      @(posedge ref_clk_in);
      for (i = 0; i < 9; i++) begin
         rd_chk(rows[i].a, 8'h00);
         wr_reg(rows[i].a, 8'hff);
         rd_chk(rows[i].a, rows[i].m);
         wr_reg(rows[i].a, 8'h00);
      end
      wr_reg(8'h20, 8'h01);
      wr_reg(8'h01, 8'h02);
      wr_reg(8'h05, 8'h03);
      start(12'h0123);
      wait_ready();
      chk(result_out, 16'h048c);
      chk(samp_len, 16'h000a);
      chk(conv_len, 16'h001c);
      rd_chk(8'h26, 8'h8c);
      rd_chk(8'h27, 8'h04);
      wr_reg(8'h01, 8'h00);
      wr_reg(8'h05, 8'h00);
      wr_reg(8'h23, 8'h04);
      wr_reg(8'h25, 8'h05);
      for (j = 0; j < 5; j++) begin
         wr_reg(8'h04, 8'(j));
         for (i = 0; i < 5; i++) begin
            start(lv[i]);
            wait_ready();
            chk(result_out, 16'(lv[i]));
            chk(16'(window_hit_flag_out), 16'(exp_win(j, 16'(lv[i]))));
         end
      end
      for (i = 0; i < 4; i++) begin
         wr_reg(8'h02, 8'(dc[i]));
         start(12'h0000);
         wait_ready();
         chk(samp_len, 16'(2 * dv[i]));
         chk(h_len, 16'(dv[i]));
      end
      wr_reg(8'h02, 8'h00);
      wr_reg(8'h20, 8'h05);
      start(12'h0000);
      wait_ready();
      chk(conv_len, 16'h0018);
      wr_reg(8'h20, 8'h01);
      // two accumulated samples with an inter-sample wait of three ticks
      wr_reg(8'h03, 8'h03);
      wr_reg(8'h01, 8'h01);
      start(12'h0111);
      wait_ready();
      chk(g_len, 16'h0006);
      chk(result_out, 16'h0222);
      wr_reg(8'h03, 8'h00);
      wr_reg(8'h01, 8'h00);
      // zero write, select deferral, queued start
      start(12'h0000);
      wr_reg(8'h0a, 8'h00);
      rd_chk(8'h0a, 8'h01);
      wr_reg(8'h08, 8'h15);
      wr_reg(8'h09, 8'h48);
      chk(16'(positive_input_sel_out), 16'h0000);
      chk(16'(negative_input_sel_out), 16'h0000);
      wr_reg(8'h0a, 8'h01);
      wait_ready();
      wr_reg(8'h21, 8'h03);
      rd_chk(8'h0a, 8'h01);
      wait_ready();
      rd_chk(8'h0a, 8'h00);
      chk(16'(positive_input_sel_out), 16'h0015);
      chk(16'(negative_input_sel_out), 16'h0048);
      start(12'h0000);
      wr_reg(8'h0a, 8'h03);
      rd_chk(8'h0a, 8'h00);
      repeat (80) @(posedge ref_clk_in);
      #1 chk(16'(result_ready_out), 16'h0000);
      wr_reg(8'h20, 8'h03);
      start(12'h0000);
      wait_ready();
      wr_reg(8'h21, 8'h03);
      wait_ready();
      wr_reg(8'h0a, 8'h02);
      wr_reg(8'h20, 8'h01);
      wr_reg(8'h03, 8'h20);
      for (i = 0; i < 2; i++) begin
         deep_wake_in <= (i == 0);
         ref_change_in <= (i == 1);
         @(posedge ref_clk_in);
         {deep_wake_in, ref_change_in} <= 2'b00;
         start(12'h0000);
         wait_ready();
         chk(16'(waited >= 56), 16'h0001);
      end
      end_sim();
   end
endmodule

// ===== verilog/adsc_cfg.svh
// register offsets, field positions and timing constants for the converter control
`ifndef ADSC_CFG_SVH
`define ADSC_CFG_SVH
`define ADSC_OFF_ACC      8'h01
`define ADSC_OFF_CLKDIV   8'h02
`define ADSC_OFF_DELAY    8'h03
`define ADSC_OFF_WINMODE  8'h04
`define ADSC_OFF_SAMPLE_EXTENSION  8'h05
`define ADSC_OFF_POSSEL   8'h08
`define ADSC_OFF_NEGSEL   8'h09
`define ADSC_OFF_CMD      8'h0a
`define ADSC_OFF_CTRL     8'h20
`define ADSC_OFF_STATUS   8'h21
`define ADSC_OFF_WINDOW_LOW_THRESHOLD_L  8'h22
`define ADSC_OFF_WINDOW_LOW_THRESHOLD_H  8'h23
`define ADSC_OFF_WINDOW_HIGH_THRESHOLD_L  8'h24
`define ADSC_OFF_WINDOW_HIGH_THRESHOLD_H  8'h25
`define ADSC_OFF_RES_L    8'h26
`define ADSC_OFF_RES_H    8'h27
`define ADSC_RST8         8'h00
`define ADSC_RST16        16'h0000
`define ADSC_MASK_ACC     8'h07
`define ADSC_MASK_CLKDIV  8'h0f
`define ADSC_MASK_DELAY   8'hef
`define ADSC_MASK_WINMODE 8'h07
`define ADSC_MASK_SEL     8'h7f
`define ADSC_MASK_CTRL    8'h07
`define ADSC_BIT_STOP     1
`define ADSC_BIT_START    0
`define ADSC_BIT_ENABLE   0
`define ADSC_BIT_CONTINUOUS_RUN  1
`define ADSC_BIT_RES10    2
`define ADSC_BASE_SAMPLE  9'h002
`define ADSC_CONV12_HALF  5'h1b
`define ADSC_CONV10_HALF  5'h17
`define ADSC_WIN_NONE     3'h0
`define ADSC_WIN_BELOW    3'h1
`define ADSC_WIN_ABOVE    3'h2
`define ADSC_WIN_INSIDE   3'h3
`define ADSC_WIN_OUTSIDE  3'h4
`endif

// ===== verilog/adsc_pkg.sv
// types shared by the converter control
package adsc_pkg;
   typedef enum logic [2:0] {
      ADSC_IDLE,
      ADSC_INIT,
      ADSC_SAMPLE,
      ADSC_CONVERT,
      ADSC_GAP
   } adsc_state_t;
endpackage

// ===== verilog/adsc_top.sv
// converter sequencing control: registers, clock divider, sequencer, window
//
// Functional notes
// - accumulate 1,2,4..128 consecutive results into the result register
// - converter clock divides peripheral clock by 2..256 per code 0..13
// - wait 0..256 converter cycles before first sample after enable
// - same startup wait applied on wake from deep sleep to measure
// - wait inter-sample field value, 0..15 converter cycles, between samples
// - sampling lasts two cycles plus the sample extension value
// - window mode: none, below, above, inside inclusive, outside
// - compare full 16-bit accumulated result to 16-bit thresholds
// - positive input selector is seven bits wide, reserved codes unchecked
// - negative input selector is seven bits wide, reserved codes unchecked
// - selector writes take effect only after the running conversion
// - writing stop ends measurement and overrides a simultaneous start
// - start waits for the ongoing conversion, launches first free-run one
// - start bit reads one while converting, clears itself on completion
// - writing zero to start or stop does nothing
// - continuous run restarts conversions after the first start
// - 10-bit resolution shortens conversion from 13.5 to 11.5 cycles
// - window check at end of the last conversion of each measurement, flag set only on match
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "adsc_cfg.svh"
module adsc_top (
   // clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_b_in,
   // register port
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [7:0]  reg_rdata_out,
   // power management
   input  wire logic        deep_wake_in,
   input  wire logic        ref_change_in,
   // analog core
   input  wire logic [11:0] sample_data_in,
   output logic             adc_clk_out,
   output logic             sampling_out,
   output logic             converting_out,
   output logic      [6:0]  positive_input_sel_out,
   output logic      [6:0]  negative_input_sel_out,
   // results
   output logic      [15:0] result_out,
   output logic             result_ready_out,
   output logic             window_hit_flag_out
);

   ////////////////////////////////////////////////////////////////////////
   // functions
   // prescaler code to divider; reserved codes fall back to 256
   function automatic logic [8:0] div_of(input logic [3:0] code);
      case (code)
         4'h0: div_of = 9'h002;
         4'h1: div_of = 9'h004;
         4'h2: div_of = 9'h008;
         4'h3: div_of = 9'h00c;
         4'h4: div_of = 9'h010;
         4'h5: div_of = 9'h014;
         4'h6: div_of = 9'h018;
         4'h7: div_of = 9'h01c;
         4'h8: div_of = 9'h020;
         4'h9: div_of = 9'h030;
         4'ha: div_of = 9'h040;
         4'hb: div_of = 9'h060;
         4'hc: div_of = 9'h080;
         default: div_of = 9'h100;
      endcase
   endfunction

   // startup wait code to cycles; reserved codes give 256
   function automatic logic [8:0] init_of(input logic [2:0] code);
      case (code)
         3'h0: init_of = 9'h000;
         3'h1: init_of = 9'h010;
         3'h2: init_of = 9'h020;
         3'h3: init_of = 9'h040;
         3'h4: init_of = 9'h080;
         default: init_of = 9'h100;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]  accumulation_control;
   logic [7:0]  clock_divider_control;
   logic [7:0]  delay_control;
   logic [7:0]  window_mode_control;
   logic [7:0]  sample_length_control;
   logic [7:0]  positive_input_select;
   logic [7:0]  negative_input_select;
   logic [7:0]  run_control;
   logic [15:0] window_low_threshold;
   logic [15:0] window_high_threshold;
   logic        start_cmd;
   logic        result_ready;
   logic        window_hit_flag;
   logic [15:0] result;
   logic        cmd_wr;
   logic        stop_req;
   logic        start_req;
   assign cmd_wr    = reg_wr_in && (reg_addr_in == `ADSC_OFF_CMD);
   assign stop_req  = cmd_wr && reg_wdata_in[`ADSC_BIT_STOP];
   assign start_req = cmd_wr && reg_wdata_in[`ADSC_BIT_START]
                      && !stop_req;

   // configuration writes, unimplemented bits masked off
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         accumulation_control  <= `ADSC_RST8;
         clock_divider_control <= `ADSC_RST8;
         delay_control         <= `ADSC_RST8;
         window_mode_control   <= `ADSC_RST8;
         sample_length_control <= `ADSC_RST8;
         positive_input_select <= `ADSC_RST8;
         negative_input_select <= `ADSC_RST8;
         run_control           <= `ADSC_RST8;
         window_low_threshold  <= `ADSC_RST16;
         window_high_threshold <= `ADSC_RST16;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `ADSC_OFF_ACC:     accumulation_control  <= reg_wdata_in & `ADSC_MASK_ACC;
            `ADSC_OFF_CLKDIV:  clock_divider_control <= reg_wdata_in & `ADSC_MASK_CLKDIV;
            `ADSC_OFF_DELAY:   delay_control         <= reg_wdata_in & `ADSC_MASK_DELAY;
            `ADSC_OFF_WINMODE: window_mode_control   <= reg_wdata_in & `ADSC_MASK_WINMODE;
            `ADSC_OFF_SAMPLE_EXTENSION: sample_length_control <= reg_wdata_in;
            `ADSC_OFF_POSSEL:  positive_input_select <= reg_wdata_in & `ADSC_MASK_SEL;
            `ADSC_OFF_NEGSEL:  negative_input_select <= reg_wdata_in & `ADSC_MASK_SEL;
            `ADSC_OFF_CTRL:    run_control           <= reg_wdata_in & `ADSC_MASK_CTRL;
            `ADSC_OFF_WINDOW_LOW_THRESHOLD_L: window_low_threshold[7:0]   <= reg_wdata_in;
            `ADSC_OFF_WINDOW_LOW_THRESHOLD_H: window_low_threshold[15:8]  <= reg_wdata_in;
            `ADSC_OFF_WINDOW_HIGH_THRESHOLD_L: window_high_threshold[7:0]  <= reg_wdata_in;
            `ADSC_OFF_WINDOW_HIGH_THRESHOLD_H: window_high_threshold[15:8] <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   logic enable;
   logic continuous_run;
   logic res10;
   assign enable  = run_control[`ADSC_BIT_ENABLE];
   assign continuous_run = run_control[`ADSC_BIT_CONTINUOUS_RUN];
   assign res10   = run_control[`ADSC_BIT_RES10];

   ////////////////////////////////////////////////////////////////////////
   // converter clock divider
   adsc_pkg::adsc_state_t state;
   logic [8:0] div_cnt;
   logic [8:0] div_n;
   logic       adc_tick;
   assign div_n    = div_of(clock_divider_control[3:0]);
   assign adc_tick = (div_cnt >= div_n - 9'h001);

   // counts peripheral cycles; held at zero while idle so phases start whole
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         div_cnt     <= 9'h000;
         adc_clk_out <= 1'b0;
      end else if (adc_tick || state == adsc_pkg::ADSC_IDLE) begin
         div_cnt     <= 9'h000;
         adc_clk_out <= 1'b0;
      end else begin
         div_cnt     <= div_cnt + 9'h001;
         adc_clk_out <= (div_cnt + 9'h001) >= {1'b0, div_n[8:1]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   logic [8:0] step;      // converter cycles spent in current phase
   logic [7:0] samp_left; // samples still to take in this measurement
   logic [7:0] samp_total;
   logic       need_init; // startup wait still owed
   logic       pending;   // start queued behind a running conversion
   logic [16:0] acc;
   logic       conv_done;
   logic [8:0] samp_len;
   logic [4:0] conv_half;
   assign samp_total = 8'h01 << accumulation_control[2:0];
   assign samp_len   = `ADSC_BASE_SAMPLE + {1'b0, sample_length_control};
   assign conv_half  = res10 ? `ADSC_CONV10_HALF : `ADSC_CONV12_HALF;

   // conversion time in half cycles, compared as doubled step count
   logic conv_end;
   assign conv_end  = ({step[7:0], 1'b0} + 9'h001) >= {4'h0, conv_half};
   assign conv_done = adc_tick && (state == adsc_pkg::ADSC_CONVERT)
                      && conv_end && (samp_left == 8'h01);

   // startup wait owed after enable, reference change or deep wake
   logic enable_q;
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         enable_q  <= 1'b0;
      end else begin
         enable_q  <= enable;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         need_init <= 1'b1;
      end else if ((enable && !enable_q) || ref_change_in || deep_wake_in) begin
         need_init <= 1'b1;
      end else if (state == adsc_pkg::ADSC_INIT) begin
         need_init <= 1'b0;
      end
   end

   // main phase machine
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state     <= adsc_pkg::ADSC_IDLE;
         step      <= 9'h000;
         samp_left <= 8'h00;
         acc       <= 17'h0_0000;
      end else if (stop_req || !enable) begin
         state     <= adsc_pkg::ADSC_IDLE;
         step      <= 9'h000;
      end else begin
         case (state)
            adsc_pkg::ADSC_IDLE: begin
               step <= 9'h000;
               acc  <= 17'h0_0000;
               samp_left <= samp_total;
               if (start_req || pending) begin
                  state <= need_init ? adsc_pkg::ADSC_INIT
                                     : adsc_pkg::ADSC_SAMPLE;
               end
            end
            adsc_pkg::ADSC_INIT: if (adc_tick) begin
               if (step + 9'h001 >= init_of(delay_control[7:5])) begin
                  state <= adsc_pkg::ADSC_SAMPLE;
                  step  <= 9'h000;
               end else begin
                  step  <= step + 9'h001;
               end
            end
            adsc_pkg::ADSC_SAMPLE: if (adc_tick) begin
               if (step + 9'h001 >= samp_len) begin
                  state <= adsc_pkg::ADSC_CONVERT;
                  step  <= 9'h000;
               end else begin
                  step  <= step + 9'h001;
               end
            end
            adsc_pkg::ADSC_CONVERT: if (adc_tick) begin
               if (conv_end) begin
                  acc  <= acc + {5'h00, sample_data_in};
                  step <= 9'h000;
                  if (samp_left == 8'h01) begin
                     state <= adsc_pkg::ADSC_IDLE;
                  end else begin
                     samp_left <= samp_left - 8'h01;
                     state <= (delay_control[3:0] == 4'h0)
                              ? adsc_pkg::ADSC_SAMPLE
                              : adsc_pkg::ADSC_GAP;
                  end
               end else begin
                  step <= step + 9'h001;
               end
            end
            adsc_pkg::ADSC_GAP: if (adc_tick) begin
               if (step + 9'h001 >= {5'h00, delay_control[3:0]}) begin
                  state <= adsc_pkg::ADSC_SAMPLE;
                  step  <= 9'h000;
               end else begin
                  step  <= step + 9'h001;
               end
            end
            default: state <= adsc_pkg::ADSC_IDLE;
         endcase
      end
   end

   // queued start, free-run restart, and the readable start bit
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pending   <= 1'b0;
         start_cmd <= 1'b0;
      end else if (stop_req || !enable) begin
         pending   <= 1'b0;
         start_cmd <= 1'b0;
      end else begin
         if (state == adsc_pkg::ADSC_IDLE) begin
            pending <= 1'b0;
         end else if (start_req) begin
            pending <= 1'b1;
         end else if (conv_done && continuous_run) begin
            pending <= 1'b1;
         end
         if (start_req || pending) begin
            start_cmd <= 1'b1;
         end else if (conv_done) begin
            start_cmd <= 1'b0;
         end
      end
   end

   // selectors latch toward the core only between conversions
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         positive_input_sel_out <= 7'h00;
         negative_input_sel_out <= 7'h00;
      end else if (state == adsc_pkg::ADSC_IDLE) begin
         positive_input_sel_out <= positive_input_select[6:0];
         negative_input_sel_out <= negative_input_select[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result and window comparator
   logic [15:0] final_res;
   logic        win_match;
   assign final_res = acc[15:0] + {4'h0, sample_data_in};

   always_comb begin
      case (window_mode_control[2:0])
         `ADSC_WIN_BELOW:   win_match = final_res < window_low_threshold;
         `ADSC_WIN_ABOVE:   win_match = final_res > window_high_threshold;
         `ADSC_WIN_INSIDE:  win_match = (final_res >= window_low_threshold)
                                    && (final_res <= window_high_threshold);
         `ADSC_WIN_OUTSIDE: win_match = (final_res < window_low_threshold)
                                    || (final_res > window_high_threshold);
         default:           win_match = 1'b0;
      endcase
   end

   logic res_read;
   logic status_w1c_ready;
   logic status_w1c_hit;
   assign res_read = reg_rd_in && ((reg_addr_in == `ADSC_OFF_RES_L)
                     || (reg_addr_in == `ADSC_OFF_RES_H));
   assign status_w1c_ready = reg_wr_in && (reg_addr_in == `ADSC_OFF_STATUS)
                             && reg_wdata_in[0];
   assign status_w1c_hit   = reg_wr_in && (reg_addr_in == `ADSC_OFF_STATUS)
                             && reg_wdata_in[1];

   // result capture and sticky flags; a new result wins over a clear
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         result          <= `ADSC_RST16;
         result_ready    <= 1'b0;
         window_hit_flag <= 1'b0;
      end else begin
         if (conv_done) begin
            result       <= final_res;
            result_ready <= 1'b1;
         end else if (res_read || status_w1c_ready) begin
            result_ready <= 1'b0;
         end
         if (conv_done && win_match) begin
            window_hit_flag <= 1'b1;
         end else if (res_read || status_w1c_hit) begin
            window_hit_flag <= 1'b0;
         end
      end
   end

   assign sampling_out        = (state == adsc_pkg::ADSC_SAMPLE);
   assign converting_out      = (state == adsc_pkg::ADSC_CONVERT);
   assign result_out          = result;
   assign result_ready_out    = result_ready;
   assign window_hit_flag_out = window_hit_flag;

   ////////////////////////////////////////////////////////////////////////
   // read port, data valid one cycle after the strobe
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= `ADSC_RST8;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `ADSC_OFF_ACC:     reg_rdata_out <= accumulation_control;
            `ADSC_OFF_CLKDIV:  reg_rdata_out <= clock_divider_control;
            `ADSC_OFF_DELAY:   reg_rdata_out <= delay_control;
            `ADSC_OFF_WINMODE: reg_rdata_out <= window_mode_control;
            `ADSC_OFF_SAMPLE_EXTENSION: reg_rdata_out <= sample_length_control;
            `ADSC_OFF_POSSEL:  reg_rdata_out <= positive_input_select;
            `ADSC_OFF_NEGSEL:  reg_rdata_out <= negative_input_select;
            `ADSC_OFF_CMD:     reg_rdata_out <= {7'h00, start_cmd};
            `ADSC_OFF_CTRL:    reg_rdata_out <= run_control;
            `ADSC_OFF_STATUS:  reg_rdata_out <= {6'h00, window_hit_flag,
                                                  result_ready};
            `ADSC_OFF_WINDOW_LOW_THRESHOLD_L: reg_rdata_out <= window_low_threshold[7:0];
            `ADSC_OFF_WINDOW_LOW_THRESHOLD_H: reg_rdata_out <= window_low_threshold[15:8];
            `ADSC_OFF_WINDOW_HIGH_THRESHOLD_L: reg_rdata_out <= window_high_threshold[7:0];
            `ADSC_OFF_WINDOW_HIGH_THRESHOLD_H: reg_rdata_out <= window_high_threshold[15:8];
            `ADSC_OFF_RES_L:   reg_rdata_out <= result[7:0];
            `ADSC_OFF_RES_H:   reg_rdata_out <= result[15:8];
            default:           reg_rdata_out <= `ADSC_RST8;
         endcase
      end else begin
         reg_rdata_out <= `ADSC_RST8;
      end
   end

endmodule
